// ===== src/fieldbus_cfg_pkg.sv
// Constants, register map and carrier types of the fieldbus master switch configuration block
package fieldbus_cfg_pkg;

  // ==========================================================================
  // Clock and link timing
  // ==========================================================================
  localparam int  CLK_HZ             = 125_000_000;
  localparam real RATE_HS_KBPS       = 750.0;
  localparam real RATE_LD_KBPS       = 93.75;
  localparam int  BIT_HS_CYC         = int'(CLK_HZ / (RATE_HS_KBPS * 1000.0));
  localparam int  BIT_LD_CYC         = int'(CLK_HZ / (RATE_LD_KBPS * 1000.0));
  localparam real CYCLE_HS_NARROW_MS = 0.5;
  localparam real CYCLE_HS_WIDE_MS   = 0.8;
  localparam real CYCLE_LD_NARROW_MS = 4.0;
  localparam real CYCLE_LD_WIDE_MS   = 6.0;
  localparam int  CYC_HS_NARROW      = int'(CYCLE_HS_NARROW_MS * CLK_HZ / 1000.0);
  localparam int  CYC_HS_WIDE        = int'(CYCLE_HS_WIDE_MS * CLK_HZ / 1000.0);
  localparam int  CYC_LD_NARROW      = int'(CYCLE_LD_NARROW_MS * CLK_HZ / 1000.0);
  localparam int  CYC_LD_WIDE        = int'(CYCLE_LD_WIDE_MS * CLK_HZ / 1000.0);
  localparam int  CYC_CNT_W          = 20;
  localparam int  BIT_CNT_W          = 12;
  localparam int  SETTLE_CYC         = 3;

  // ==========================================================================
  // Allocation figures
  // ==========================================================================
  localparam logic [6:0] UNIT_MAX_NARROW    = 7'd95;
  localparam logic [6:0] UNIT_MAX_WIDE      = 7'd94;
  localparam logic [3:0] DIGIT_MAX          = 4'h9;
  localparam logic [6:0] TENS_WEIGHT        = 7'd10;
  localparam logic [4:0] WORDS_NARROW       = 5'd10;
  localparam logic [4:0] WORDS_WIDE         = 5'd20;
  localparam logic [3:0] IN_WORDS_NARROW    = 4'h4;
  localparam logic [3:0] IN_WORDS_WIDE      = 4'h8;
  localparam logic [3:0] OUT_WORDS_NARROW   = 4'h4;
  localparam logic [3:0] OUT_WORDS_WIDE     = 4'h8;
  localparam logic [2:0] STAT_WORDS_NARROW  = 3'h2;
  localparam logic [2:0] STAT_WORDS_WIDE    = 3'h4;
  localparam logic [4:0] NODES_NARROW       = 5'd8;
  localparam logic [4:0] NODES_WIDE         = 5'd16;
  localparam logic [15:0] NODE_MASK_NARROW  = 16'h00ff;
  localparam logic [15:0] NODE_MASK_WIDE    = 16'hffff;

  // ==========================================================================
  // Register map (byte addresses) and interrupt bits
  // ==========================================================================
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_STATE    = 8'h04;
  localparam logic [7:0] ADDR_CONTROL  = 8'h08;
  localparam logic [7:0] ADDR_REGTAB   = 8'h0c;
  localparam logic [7:0] ADDR_MISSING  = 8'h10;
  localparam logic [7:0] ADDR_UNREG    = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1c;
  localparam int INT_W        = 5;
  localparam int INT_SET_ERR  = 0;
  localparam int INT_LINK_ERR = 1;
  localparam int INT_HALT     = 2;
  localparam int INT_MISSING  = 3;
  localparam int INT_UNREG    = 4;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 5'h00;
  localparam logic [31:0]      REGTAB_RESET   = 32'h0000_0000;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] unit_tens;
    logic [3:0] unit_ones;
    logic       wide_range;
    logic       long_distance;
    logic       stop_on_error;
    logic       reg_check;
  } switch_cfg_t;

  typedef struct packed {
    logic [6:0] unit_number;
    logic [4:0] words_total;
    logic [3:0] in_words;
    logic [3:0] out_words;
    logic [2:0] status_words;
    logic [4:0] node_count;
    logic       wide_range;
    logic       long_distance;
    logic       stop_on_error;
    logic       reg_check;
  } link_cfg_t;

  localparam switch_cfg_t SHIPPED_SWITCHES = '0;

  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_CHECK,
    ST_RUN,
    ST_SET_ERROR,
    ST_HALTED
  } cfg_state_t;

endpackage

// ===== src/fieldbus_master_switch_config.sv
// Switch capture, allocation, link timing, error policy and slave check of the fieldbus master
//
// Contract
// - Unit number comes from two decimal rotary switches, tens and units.
// - Narrow range serves nodes 0-7, allocates 4 in, 4 out, 2 status words.
// - Wide range serves nodes 0-15, allocates 8 in, 8 out, 4 status words.
// - Shipped unit number reads zero on both digits.
// - Shipped option switches are all off.
// - Speed switch off gives 750 kbps, on gives 93.75 kbps.
// - Cycle time is 0.5/0.8 ms high-speed, 4.0/6.0 ms long-distance.
// - All parties share one speed; master lamp ignores mismatched slaves.
// - Stop-on-error off keeps exchanging after link error; on halts it.
// - A halted exchange resumes only after reset or unit restart.
// - Registration check switch on enables slave checking, off disables it.
// - Checking flags missing slaves and unregistered slaves against host table.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns

module fieldbus_master_switch_config
  import fieldbus_cfg_pkg::*;
#(
  parameter int CYCLE_HS_NARROW = fieldbus_cfg_pkg::CYC_HS_NARROW,
  parameter int CYCLE_HS_WIDE   = fieldbus_cfg_pkg::CYC_HS_WIDE,
  parameter int CYCLE_LD_NARROW = fieldbus_cfg_pkg::CYC_LD_NARROW,
  parameter int CYCLE_LD_WIDE   = fieldbus_cfg_pkg::CYC_LD_WIDE
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire fieldbus_cfg_pkg::switch_cfg_t switch_pins,
  input  wire logic                          link_error,
  input  wire logic [31:0]                   slave_present,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  output fieldbus_cfg_pkg::link_cfg_t        link_cfg,
  output logic                               exchange_run,
  output logic                               link_ok_lamp,
  output logic                               setting_error,
  output logic                               exchange_halted,
  output logic                               bit_tick,
  output logic                               cycle_tick,
  output logic [31:0]                        slave_missing,
  output logic [31:0]                        slave_unregistered,
  output logic                               irq
);
  import fieldbus_cfg_pkg::*;

  initial begin
    if (CYCLE_HS_NARROW < 1 || CYCLE_HS_WIDE < 1 || CYCLE_LD_NARROW < 1 || CYCLE_LD_WIDE < 1)
      $error("cycle counts must be at least one");
    if (CYCLE_HS_NARROW >= 2**CYC_CNT_W || CYCLE_HS_WIDE >= 2**CYC_CNT_W ||
        CYCLE_LD_NARROW >= 2**CYC_CNT_W || CYCLE_LD_WIDE >= 2**CYC_CNT_W)
      $error("cycle counts exceed the cycle counter width");
  end

  // ==========================================================================
  // Switch synchroniser
  // ==========================================================================
  // Switches are mechanical pins from outside the clock domain
  switch_cfg_t sw_meta_reg;
  switch_cfg_t sw_sync_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_meta_reg <= SHIPPED_SWITCHES;
      sw_sync_reg <= SHIPPED_SWITCHES;
    end else begin
      sw_meta_reg <= switch_pins;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // ==========================================================================
  // Wishbone decode and software registers
  // ==========================================================================
  logic                 bus_req;
  logic                 bus_wr;
  logic [31:0]          byte_mask;
  logic                 restart_ctl_reg;
  logic                 restart_pulse;
  logic [31:0]          regtab_reg;
  logic [INT_W-1:0]     int_stat_reg;
  logic [INT_W-1:0]     int_stat_next;
  logic [INT_W-1:0]     int_mask_reg;
  logic [INT_W-1:0]     int_set;
  logic [INT_W-1:0]     int_clr;

  assign bus_req   = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign bus_wr    = bus_req & wb_we_i & wb_ack_o;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      restart_ctl_reg <= 1'b0;
    end else if (bus_wr && wb_adr_i == ADDR_CONTROL && wb_sel_i[0]) begin
      restart_ctl_reg <= wb_dat_i[0];
    end
  end

  // Restart fires on the falling write of the control bit, after it was set
  assign restart_pulse = bus_wr && wb_adr_i == ADDR_CONTROL && wb_sel_i[0] &&
                         restart_ctl_reg && !wb_dat_i[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      regtab_reg <= REGTAB_RESET;
    end else if (bus_wr && wb_adr_i == ADDR_REGTAB) begin
      regtab_reg <= (regtab_reg & ~byte_mask) | (wb_dat_i & byte_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      int_mask_reg <= INT_MASK_RESET;
    end else if (bus_wr && wb_adr_i == ADDR_INT_MASK && wb_sel_i[0]) begin
      int_mask_reg <= wb_dat_i[INT_W-1:0];
    end
  end

  // ==========================================================================
  // Capture state machine
  // ==========================================================================
  cfg_state_t  state_reg;
  logic [1:0]  settle_cnt_reg;
  switch_cfg_t cap_reg;
  logic [6:0]  unit_value;
  logic [6:0]  unit_limit;
  logic        digits_ok;
  logic        range_ok;
  logic        err_halt;

  // Decimal digits; with both digits at most 9 the sum stays below 100 so seven bits hold it
  assign unit_value = (TENS_WEIGHT * {3'h0, cap_reg.unit_tens}) + {3'h0, cap_reg.unit_ones};
  assign unit_limit = cap_reg.wide_range ? UNIT_MAX_WIDE : UNIT_MAX_NARROW;
  assign digits_ok  = (cap_reg.unit_tens <= DIGIT_MAX) && (cap_reg.unit_ones <= DIGIT_MAX);
  assign range_ok   = digits_ok && (unit_value <= unit_limit);
  assign err_halt   = cap_reg.stop_on_error && link_error;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg      <= ST_SETTLE;
      settle_cnt_reg <= 2'h0;
    end else if (restart_pulse) begin
      state_reg      <= ST_SETTLE;
      settle_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_SETTLE: begin
          // Wait for the synchroniser to carry real pin levels
          if (settle_cnt_reg == 2'(SETTLE_CYC - 1)) begin
            state_reg <= ST_CHECK;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 2'h1;
          end
        end
        ST_CHECK: begin
          state_reg <= range_ok ? ST_RUN : ST_SET_ERROR;
        end
        ST_RUN: begin
          if (err_halt) begin
            state_reg <= ST_HALTED;
          end
        end
        ST_SET_ERROR: begin
          state_reg <= ST_SET_ERROR;
        end
        ST_HALTED: begin
          // Clearing of the link fault does not matter here
          state_reg <= ST_HALTED;
        end
        default: begin
          state_reg <= ST_SETTLE;
        end
      endcase
    end
  end

  // Settings are latched once per start and frozen after that
  always_ff @(posedge clk) begin
    if (reset) begin
      cap_reg <= SHIPPED_SWITCHES;
    end else if (state_reg == ST_SETTLE && settle_cnt_reg == 2'(SETTLE_CYC - 1)) begin
      cap_reg <= sw_sync_reg;
    end
  end

  // ==========================================================================
  // Allocation output
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      link_cfg <= '0;
    end else if (state_reg == ST_CHECK) begin
      link_cfg.unit_number   <= unit_value;
      link_cfg.wide_range    <= cap_reg.wide_range;
      link_cfg.long_distance <= cap_reg.long_distance;
      link_cfg.stop_on_error <= cap_reg.stop_on_error;
      link_cfg.reg_check     <= cap_reg.reg_check;
      if (cap_reg.wide_range) begin
        link_cfg.words_total  <= WORDS_WIDE;
        link_cfg.in_words     <= IN_WORDS_WIDE;
        link_cfg.out_words    <= OUT_WORDS_WIDE;
        link_cfg.status_words <= STAT_WORDS_WIDE;
        link_cfg.node_count   <= NODES_WIDE;
      end else begin
        link_cfg.words_total  <= WORDS_NARROW;
        link_cfg.in_words     <= IN_WORDS_NARROW;
        link_cfg.out_words    <= OUT_WORDS_NARROW;
        link_cfg.status_words <= STAT_WORDS_NARROW;
        link_cfg.node_count   <= NODES_NARROW;
      end
    end
  end

  assign exchange_run    = (state_reg == ST_RUN);
  assign setting_error   = (state_reg == ST_SET_ERROR);
  assign exchange_halted = (state_reg == ST_HALTED);
  // Lamp follows the master's own link only; a slave on the wrong speed cannot dim it
  assign link_ok_lamp    = exchange_run && !link_error;

  // ==========================================================================
  // Bit and cycle timers
  // ==========================================================================
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_len;
  logic [CYC_CNT_W-1:0] cyc_cnt_reg;
  logic [CYC_CNT_W-1:0] cyc_len;

  assign bit_len = cap_reg.long_distance ? BIT_CNT_W'(BIT_LD_CYC) : BIT_CNT_W'(BIT_HS_CYC);

  always_comb begin
    case ({cap_reg.long_distance, cap_reg.wide_range})
      2'b00:   cyc_len = CYC_CNT_W'(CYCLE_HS_NARROW);
      2'b01:   cyc_len = CYC_CNT_W'(CYCLE_HS_WIDE);
      2'b10:   cyc_len = CYC_CNT_W'(CYCLE_LD_NARROW);
      2'b11:   cyc_len = CYC_CNT_W'(CYCLE_LD_WIDE);
      default: cyc_len = CYC_CNT_W'(CYCLE_HS_NARROW);
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || !exchange_run) begin
      bit_cnt_reg <= '0;
      bit_tick    <= 1'b0;
    end else if (bit_cnt_reg == bit_len - BIT_CNT_W'(1)) begin
      bit_cnt_reg <= '0;
      bit_tick    <= 1'b1;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
      bit_tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !exchange_run) begin
      cyc_cnt_reg <= '0;
      cycle_tick  <= 1'b0;
    end else if (cyc_cnt_reg == cyc_len - CYC_CNT_W'(1)) begin
      cyc_cnt_reg <= '0;
      cycle_tick  <= 1'b1;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + CYC_CNT_W'(1);
      cycle_tick  <= 1'b0;
    end
  end

  // ==========================================================================
  // Slave registration check
  // ==========================================================================
  // Low half holds input nodes, high half output nodes
  logic [31:0] node_mask;
  logic [31:0] missing_next;
  logic [31:0] unreg_next;
  logic        check_on;

  assign node_mask    = cap_reg.wide_range ? {NODE_MASK_WIDE, NODE_MASK_WIDE}
                                           : {NODE_MASK_NARROW, NODE_MASK_NARROW};
  assign check_on     = exchange_run && cap_reg.reg_check;
  assign missing_next = regtab_reg & ~slave_present & node_mask;
  assign unreg_next   = slave_present & ~regtab_reg & node_mask;

  always_ff @(posedge clk) begin
    if (reset || !check_on) begin
      slave_missing      <= '0;
      slave_unregistered <= '0;
    end else begin
      slave_missing      <= missing_next;
      slave_unregistered <= unreg_next;
    end
  end

  // ==========================================================================
  // Interrupt status
  // ==========================================================================
  always_comb begin
    int_set               = '0;
    int_set[INT_SET_ERR]  = (state_reg == ST_CHECK) && !range_ok;
    int_set[INT_LINK_ERR] = exchange_run && link_error;
    int_set[INT_HALT]     = exchange_run && err_halt;
    int_set[INT_MISSING]  = check_on && (missing_next != 32'h0000_0000);
    int_set[INT_UNREG]    = check_on && (unreg_next != 32'h0000_0000);
  end

  assign int_clr = (bus_wr && wb_adr_i == ADDR_INT_STAT && wb_sel_i[0]) ? wb_dat_i[INT_W-1:0] : '0;
  // A new event beats a clear in the same cycle
  assign int_stat_next = (int_stat_reg & ~int_clr) | int_set;

  always_ff @(posedge clk) begin
    if (reset) begin
      int_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      irq          <= |(int_stat_next & int_mask_reg);
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      case (wb_adr_i)
        ADDR_CONFIG:   wb_dat_o <= 32'(link_cfg);
        ADDR_STATE:    wb_dat_o <= {24'h000000, cap_reg.unit_tens, cap_reg.unit_ones} << 8 |
                                   {29'h0, exchange_halted, setting_error, exchange_run};
        ADDR_CONTROL:  wb_dat_o <= {31'h0, restart_ctl_reg};
        ADDR_REGTAB:   wb_dat_o <= regtab_reg;
        ADDR_MISSING:  wb_dat_o <= slave_missing;
        ADDR_UNREG:    wb_dat_o <= slave_unregistered;
        ADDR_INT_STAT: wb_dat_o <= {27'h0, int_stat_reg};
        ADDR_INT_MASK: wb_dat_o <= {27'h0, int_mask_reg};
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // fieldbus_master_switch_config

// ===== tb/fieldbus_assertions.sv
// Concurrent checks on the ports of the fieldbus master switch configuration block
`timescale 1ns/1ns

module fieldbus_assertions
  import fieldbus_cfg_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic                          link_error,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_ack_o,
  input wire fieldbus_cfg_pkg::link_cfg_t   link_cfg,
  input wire logic                          exchange_run,
  input wire logic                          link_ok_lamp,
  input wire logic                          setting_error,
  input wire logic                          exchange_halted,
  input wire logic [31:0]                   slave_missing,
  input wire logic [31:0]                   slave_unregistered
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");

  // ==========================================================================
  // Configuration and link policy
  // ==========================================================================
  chk_lamp_follows_link: assert property (link_ok_lamp == (exchange_run && !link_error))
    else $error("lamp does not follow run and link state");
  chk_halt_on_error: assert property (exchange_run && link_cfg.stop_on_error && link_error |=> exchange_halted)
    else $error("no halt after link error in stop mode");
  chk_keep_running: assert property (exchange_run && !link_cfg.stop_on_error && !wb_cyc_i |=> exchange_run)
    else $error("exchange stopped in continue mode");
  chk_halt_holds: assert property (exchange_halted && !wb_cyc_i |=> exchange_halted)
    else $error("halt released without restart");
  chk_cfg_held: assert property (exchange_run |=> $stable(link_cfg))
    else $error("configuration changed while running");
  chk_words_alloc: assert property (exchange_run |-> link_cfg.words_total == (link_cfg.wide_range ? 5'd20 : 5'd10)
      && link_cfg.status_words == (link_cfg.wide_range ? 3'h4 : 3'h2))
    else $error("word allocation wrong for node range");
  chk_run_in_range: assert property (exchange_run |-> link_cfg.unit_number <= (link_cfg.wide_range ? 7'd94 : 7'd95))
    else $error("running with unit number out of range");
  chk_err_no_run: assert property (setting_error |-> !exchange_run && !link_ok_lamp)
    else $error("link up despite setting error");
  chk_check_off: assert property (!link_cfg.reg_check |-> (slave_missing | slave_unregistered) == 32'h0)
    else $error("slave flags while checking disabled");
endmodule // fieldbus_assertions

bind fieldbus_master_switch_config fieldbus_assertions chk_i (
  .clk(clk), .reset(reset), .link_error(link_error), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .link_cfg(link_cfg), .exchange_run(exchange_run), .link_ok_lamp(link_ok_lamp),
  .setting_error(setting_error), .exchange_halted(exchange_halted), .slave_missing(slave_missing),
  .slave_unregistered(slave_unregistered)
);

// ===== tb/slave_link_model.sv
// Behavioural model of the remote slaves and the link fault source
`timescale 1ns/1ns

module slave_link_model (
  input  wire logic        clk,
  input  wire logic [31:0] present_req,
  input  wire logic        err_req,
  output logic [31:0]      slave_present,
  output logic             link_error
);
  initial begin
    slave_present = 32'h0;
    link_error    = 1'b0;
  end
  // Every slave shares the master speed, so only commanded nodes show up
  always @(posedge clk) begin
    slave_present <= present_req;
    link_error    <= err_req;
  end
endmodule // slave_link_model

// ===== tb/tb.sv
// Self-checking bench of the fieldbus master switch configuration block
`timescale 1ns/1ns

module tb;
  import fieldbus_cfg_pkg::*;
  typedef struct packed {
    switch_cfg_t sw;
    logic        err;
    int          cyc;
    int          bitl;
  } row_t;
  logic        clk, reset, cyc, stb, we, err_req, link_error, ack, run, lamp, serr, halt, btk, ctk, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, present_req, present, miss, unreg;
  switch_cfg_t sw;
  link_cfg_t   cfg;
  row_t        rows [8];
  int          num_errors, total_checks, n, cycles;

  fieldbus_master_switch_config #(.CYCLE_HS_NARROW(20), .CYCLE_HS_WIDE(32), .CYCLE_LD_NARROW(40),
    .CYCLE_LD_WIDE(60)) DUT (
    .clk(clk), .reset(reset), .switch_pins(sw), .link_error(link_error), .slave_present(present),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_cfg(cfg), .exchange_run(run), .link_ok_lamp(lamp),
    .setting_error(serr), .exchange_halted(halt), .bit_tick(btk), .cycle_tick(ctk),
    .slave_missing(miss), .slave_unregistered(unreg), .irq(irq));
  slave_link_model partner (.clk(clk), .present_req(present_req), .err_req(err_req),
    .slave_present(present), .link_error(link_error));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic link_cfg_t exp_cfg(input switch_cfg_t s);
    link_cfg_t c;
    c.unit_number   = 7'(s.unit_tens) * 7'd10 + 7'(s.unit_ones);
    c.words_total   = s.wide_range ? 5'd20 : 5'd10;
    c.in_words      = s.wide_range ? 4'h8 : 4'h4;
    c.out_words     = s.wide_range ? 4'h8 : 4'h4;
    c.status_words  = s.wide_range ? 3'h4 : 3'h2;
    c.node_count    = s.wide_range ? 5'd16 : 5'd8;
    c.wide_range    = s.wide_range;
    c.long_distance = s.long_distance;
    c.stop_on_error = s.stop_on_error;
    c.reg_check     = s.reg_check;
    return c;
  endfunction

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic restart(input switch_cfg_t s);
    @(posedge clk);
    sw <= s;
    bus(1'b1, 8'h08, 32'h1, q);
    bus(1'b1, 8'h08, 32'h0, q);
    repeat (8) @(posedge clk);
  endtask

  task automatic gap(input logic b, output int m);
    do @(posedge clk); while ((b ? btk : ctk) !== 1'b1);
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while ((b ? btk : ctk) !== 1'b1);
  endtask

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang costs a mismatch and ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {reset, cyc, stb, we, err_req} = 5'h10;
    {adr, wdat, present_req, sw} = '0;
    sel = 4'hf;
    {num_errors, total_checks, cycles} = '0;
    rows = '{'{12'h000, 1'b0, 20, 167}, '{12'h950, 1'b0, 20, 167}, '{12'h960, 1'b1, 0, 0},
             '{12'h948, 1'b0, 32, 167}, '{12'h958, 1'b1, 0, 0}, '{12'h424, 1'b0, 40, 1333},
             '{12'h17f, 1'b0, 60, 1333}, '{12'h0a0, 1'b1, 0, 0}};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    check_val(32'(cfg), 32'(exp_cfg(12'h000)));
    check_val({31'h0, run}, 32'h1);
    bus(1'b0, 8'h00, 32'h0, q);
    check_val(q, 32'(exp_cfg(12'h000)));
    bus(1'b0, 8'h0c, 32'h0, q);
    check_val(q, 32'h0);
    bus(1'b0, 8'h1c, 32'h0, q);
    check_val(q, 32'h0);
    bus(1'b0, 8'h20, 32'h0, q);
    check_val(q, 32'h0);
    foreach (rows[i]) begin
      restart(rows[i].sw);
      check_val(32'(cfg), 32'(exp_cfg(rows[i].sw)));
      check_val({30'h0, run, serr}, {30'h0, !rows[i].err, rows[i].err});
      bus(1'b0, 8'h04, 32'h0, q);
      check_val(q & 32'hff03, {16'h0, rows[i].sw[11:4], 6'h0, rows[i].err, !rows[i].err});
      if (!rows[i].err) begin
        gap(1'b0, n);
        check_val(32'(n), 32'(rows[i].cyc));
        gap(1'b1, n);
        check_val(32'(n), 32'(rows[i].bitl));
      end
    end
    restart(12'h948);
    sw <= 12'h17f;
    repeat (10) @(posedge clk);
    check_val(32'(cfg), 32'(exp_cfg(12'h948)));
    err_req <= 1'b1;
    repeat (3) @(posedge clk);
    check_val({29'h0, lamp, run, irq}, 32'h2);
    err_req <= 1'b0;
    bus(1'b1, 8'h1c, 32'h2, q);
    repeat (2) @(posedge clk);
    check_val({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h18, 32'h2, q);
    repeat (2) @(posedge clk);
    check_val({31'h0, irq}, 32'h0);
    restart(12'h952);
    err_req <= 1'b1;
    repeat (4) @(posedge clk);
    err_req <= 1'b0;
    repeat (6) @(posedge clk);
    check_val({30'h0, halt, run}, 32'h2);
    restart(12'h952);
    check_val({30'h0, halt, run}, 32'h1);
    present_req <= 32'h0001_0201;
    bus(1'b1, 8'h0c, 32'h3, q);
    restart(12'h301);
    check_val(miss, 32'h2);
    check_val(unreg, 32'h0001_0000);
    restart(12'h309);
    check_val(unreg, 32'h0001_0200);
    bus(1'b0, 8'h0c, 32'h0, q);
    check_val(q, 32'h3);
    restart(12'h308);
    check_val(miss | unreg, 32'h0);
    conclude();
  end
endmodule // tb
